// File: spia_params.svh
// Purpose: Named constants for the SPI request handler.
// Assumes: 16-bit frames, MSB first, command fields as laid out below.
// Notes: Functional notes follow.
`ifndef SPIA_PARAMS_SVH
`define SPIA_PARAMS_SVH
`define SPIA_FRAME_EDGES 5'h10
`define SPIA_CNT_MAX 5'h1F
`define SPIA_CFG_OC 7
`define SPIA_CFG_SD 4
`define SPIA_CFG_AF1 2
`define SPIA_CFG_AF0 1
`define SPIA_CMD_LEN 3
`define SPIA_CMD_OC 2
`define SPIA_CMD_SD 1
`define SPIA_CMD_TRG 0
`define SPIA_RSP_PAR 12
`define SPIA_RSP_MSB 15
`define SPIA_ACC_HDR 2'h2
`define SPIA_NIB_REG 4'hE
`define SPIA_NIB_MISO 4'hC
`define SPIA_NIB_INT 4'hD
`define SPIA_NIB_SPI 4'hB
`define SPIA_NIB_IACC 4'hA
`define SPIA_NIB_IREG 4'hF
`define SPIA_RSP_IDLE 16'h0000
`define SPIA_FIFO_DEPTH 2
`endif

// File: spia_pkg.sv
// Purpose: Types shared by the SPI request handler.
// Assumes: Constants come from spia_params.svh.
// Notes: Command word layout, MSB first.
`default_nettype none
package spia_pkg;
   // Received command word.
   typedef struct packed {
      logic odd_check_bit;
      logic sensor_mode_bit;
      logic selector_bit;
      logic [4:0] addr;
      logic [7:0] data;
   } spia_cmd_s;
   // Device status inputs that gate acceleration data.
   typedef struct packed {
      logic init_pending_flag;
      logic reset_occurred_flag;
      logic internal_data_error_flag;
      logic self_test_err;
      logic offset_mon_err;
   } spia_stat_s;
   // Register access request toward the register block.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [7:0] wdata;
   } spia_reg_s;
endpackage
`default_nettype wire

// File: spia_handler.sv
// Purpose: SPI command decoder and response generator.
// Assumes: SPI mode 0, MSB first, pins asynchronous to i_mclk.
// Notes: Replies are queued and shifted out in the following frame.
`timescale 1ns/1ps
`include "spia_params.svh"
`default_nettype none
module spia_handler (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   input wire logic i_miso_sense,
   input wire logic [7:0] i_device_config_register,
   input wire spia_pkg::spia_stat_s i_stat,
   input wire logic [11:0] i_accel,
   input wire logic [7:0] i_reg_rdata,
   input wire logic i_reg_bad,
   output logic o_miso,
   output logic o_miso_oe_n,
   output spia_pkg::spia_reg_s o_reg,
   output logic o_spi_err,
   output logic o_miso_err,
   output logic o_mismatch
);

   // Sets the odd-parity bit of a reply word.
   function automatic logic [15:0] fix_par(input logic [15:0] w);
      logic [15:0] t;
      t = w;
      t[`SPIA_RSP_PAR] = 1'h0;
      t[`SPIA_RSP_PAR] = ~^t;
      return t;
   endfunction

   // Builds a reply with a code nibble and a data byte.
   function automatic logic [15:0] mk(input logic sel, input logic [3:0] n,
                                      input logic [7:0] d);
      return fix_par({2'h0, sel, 1'h0, n, d});
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   logic [1:0] s_sclk, s_cs, s_mosi, s_sense;
   logic sclk_d, cs_d;

   // Two flops on each pin before any logic looks at it.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         s_sclk <= 2'h0;
         s_cs <= 2'h3;
         s_mosi <= 2'h0;
         s_sense <= 2'h0;
         sclk_d <= 1'h0;
         cs_d <= 1'h1;
      end else begin
         s_sclk <= {s_sclk[0], i_sclk};
         s_cs <= {s_cs[0], i_cs_n};
         s_mosi <= {s_mosi[0], i_mosi};
         s_sense <= {s_sense[0], i_miso_sense};
         sclk_d <= s_sclk[1];
         cs_d <= s_cs[1];
      end
   end

   logic sclk_rise, sclk_fall, cs_fall, cs_rise, cs_act;
   assign cs_act = ~s_cs[1];
   assign sclk_rise = cs_act & s_sclk[1] & ~sclk_d;
   assign sclk_fall = cs_act & ~s_sclk[1] & sclk_d;
   assign cs_fall = ~s_cs[1] & cs_d;
   assign cs_rise = s_cs[1] & ~cs_d;

   ////////////////////////////////////////////////////////////////////////
   // Two-entry reply buffer.
   logic [15:0] fifo [`SPIA_FIFO_DEPTH];
   logic wp, rp;
   logic [1:0] fcnt;
   logic push, pop, f_full, f_empty;
   logic [15:0] push_word;
   assign f_full = (fcnt == 2'h2);
   assign f_empty = (fcnt == 2'h0);
   assign pop = cs_fall & ~f_empty;

   // Pointers and count; a push stalls while full.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         wp <= 1'h0;
         rp <= 1'h0;
         fcnt <= 2'h0;
      end else begin
         if (push & ~f_full) begin
            wp <= ~wp;
         end
         if (pop) begin
            rp <= ~rp;
         end
         fcnt <= fcnt + 2'((push & ~f_full) ? 1 : 0) - 2'(pop ? 1 : 0);
      end
   end

   // Buffer storage.
   always_ff @(posedge i_mclk) begin
      if (push & ~f_full) begin
         fifo[wp] <= push_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shift engine.
   logic [15:0] rx_sh, tx_sh;
   logic [4:0] edges;
   logic miso_bad;

   // Receive side counts rising edges and checks the MISO readback.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         rx_sh <= 16'h0000;
         edges <= 5'h00;
         miso_bad <= 1'h0;
      end else if (cs_fall) begin
         edges <= 5'h00;
         miso_bad <= 1'h0;
      end else if (sclk_rise) begin
         rx_sh <= {rx_sh[14:0], s_mosi[1]};
         if (edges != `SPIA_CNT_MAX) begin
            edges <= edges + 5'h01;
         end
         if (s_sense[1] != o_miso) begin
            miso_bad <= 1'h1;
         end
      end
   end

   // Word loaded at frame start: the queued reply, or idle when none waits.
   logic [15:0] next_tx;
   assign next_tx = f_empty ? `SPIA_RSP_IDLE : fifo[rp];

   // Transmit side loads the queued reply at frame start.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         tx_sh <= `SPIA_RSP_IDLE;
         o_miso <= 1'h0;
         o_miso_oe_n <= 1'h1;
      end else begin
         o_miso_oe_n <= s_cs[1];
         if (cs_fall) begin
            tx_sh <= next_tx;
            o_miso <= next_tx[`SPIA_RSP_MSB];
         end else if (sclk_fall) begin
            tx_sh <= {tx_sh[14:0], 1'h0};
            o_miso <= tx_sh[`SPIA_RSP_MSB - 1];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame end capture.
   spia_pkg::spia_cmd_s cmd;
   logic eval, frm_err, mis_l;

   // Latches the command and framing checks when chip select rises.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cmd <= '0;
         eval <= 1'h0;
         frm_err <= 1'h0;
         mis_l <= 1'h0;
      end else begin
         if (cs_rise) begin
            cmd <= rx_sh;
            frm_err <= (edges != `SPIA_FRAME_EDGES) | sclk_d;
            mis_l <= miso_bad;
            eval <= 1'h1;
         end else if (eval & ~f_full) begin
            eval <= 1'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decode and reply selection.
   logic is_acc, spi_err, mismatch, inv_acc, rd_ok, wr_ok;
   logic [7:0] cfg;
   assign cfg = i_device_config_register;
   assign is_acc = cmd.sensor_mode_bit;

   // Mismatch between requested and programmed configuration.
   assign mismatch = is_acc & (
      (cmd.data[`SPIA_CMD_OC] != cfg[`SPIA_CFG_OC]) |
      (cmd.data[`SPIA_CMD_SD] != cfg[`SPIA_CFG_SD]) |
      (cmd.data[`SPIA_CMD_TRG] !=
       (cfg[`SPIA_CFG_AF1] | cfg[`SPIA_CFG_AF0])));

   // Framing, parity and reserved-bit errors.
   assign spi_err = frm_err | ~(^cmd) |
      (is_acc & ((cmd.addr[3:0] != 4'h0) | (cmd.data[7:4] != 4'h0) |
                 ~cmd.data[`SPIA_CMD_LEN])) |
      (~is_acc & ~cmd.selector_bit & (cmd.data != 8'h00));

   assign inv_acc = is_acc & (cmd.selector_bit | mismatch);
   assign rd_ok = ~is_acc & ~cmd.selector_bit & ~spi_err & ~mis_l &
                  ~i_reg_bad;
   assign wr_ok = ~is_acc & cmd.selector_bit & ~spi_err & ~i_reg_bad;
   assign push = eval;

   // Picks one reply by priority; data only when every gate passes.
   always_comb begin
      if (spi_err) begin
         push_word = mk(1'h0, `SPIA_NIB_SPI, 8'h00);
      end else if (mis_l) begin
         push_word = mk(1'h0, `SPIA_NIB_MISO, 8'h00);
      end else if (inv_acc) begin
         push_word = mk(1'h0, `SPIA_NIB_IACC, 8'h00);
      end else if (~is_acc & i_reg_bad) begin
         push_word = mk(1'h0, `SPIA_NIB_IREG, 8'h00);
      end else if (~is_acc) begin
         // A write answers with the byte just written, the new contents;
         // the outside read port still shows the old value at this point.
         push_word = mk(cmd.selector_bit, `SPIA_NIB_REG,
                        cmd.selector_bit ? cmd.data : i_reg_rdata);
      end else if (i_stat.init_pending_flag |
                   i_stat.reset_occurred_flag |
                   i_stat.internal_data_error_flag |
                   i_stat.self_test_err |
                   i_stat.offset_mon_err) begin
         push_word = mk(1'h0, `SPIA_NIB_INT, 8'h00);
      end else begin
         push_word = fix_par({`SPIA_ACC_HDR, 1'h0, 1'h0, i_accel});
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs toward the register block and event flags.
   // The address is held from frame end so read data is ready at eval.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_reg <= '0;
         o_spi_err <= 1'h0;
         o_miso_err <= 1'h0;
         o_mismatch <= 1'h0;
      end else begin
         if (cs_rise) begin
            o_reg.addr <= rx_sh[12:8];
            o_reg.wdata <= rx_sh[7:0];
         end
         o_reg.wr <= eval & ~f_full & wr_ok;
         o_reg.rd <= eval & ~f_full & rd_ok;
         o_spi_err <= eval & ~f_full & spi_err;
         o_miso_err <= eval & ~f_full & mis_l;
         o_mismatch <= eval & ~f_full & ~spi_err & mismatch;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   a_edge_count: assert property (@(posedge i_mclk)
      disable iff (i_rst)
      cs_rise && edges != `SPIA_FRAME_EDGES |=> frm_err)
      else $error("wrong edge count not flagged");
   a_parity_err: assert property (@(posedge i_mclk)
      disable iff (i_rst)
      eval && !f_full && !(^cmd) |=> o_spi_err)
      else $error("even parity not flagged");
   a_mismatch: assert property (@(posedge i_mclk)
      disable iff (i_rst)
      eval && !spi_err && !mis_l && mismatch |->
      push_word[11:8] == `SPIA_NIB_IACC)
      else $error("mismatch sent data");
   a_sel_inval: assert property (@(posedge i_mclk)
      disable iff (i_rst)
      eval && is_acc && cmd.selector_bit |->
      push_word[15:14] != `SPIA_ACC_HDR)
      else $error("selector one gave data");
   a_status_gate: assert property (@(posedge i_mclk)
      disable iff (i_rst)
      eval && is_acc && (i_stat.init_pending_flag ||
      i_stat.reset_occurred_flag || i_stat.internal_data_error_flag) |->
      push_word[15:14] != `SPIA_ACC_HDR)
      else $error("data sent while status flag set");
   a_fault_gate: assert property (@(posedge i_mclk)
      disable iff (i_rst)
      eval && (i_stat.self_test_err || i_stat.offset_mon_err) |->
      push_word[15:14] != `SPIA_ACC_HDR)
      else $error("data sent during fault");
   a_miso_gate: assert property (@(posedge i_mclk)
      disable iff (i_rst)
      eval && mis_l |-> push_word[11:8] != `SPIA_NIB_REG &&
      push_word[15:14] != `SPIA_ACC_HDR)
      else $error("reply sent despite MISO error");
   // Accel data may hold the register nibble, so only register replies.
   a_reg_format: assert property (@(posedge i_mclk)
      disable iff (i_rst)
      push && !is_acc && push_word[11:8] == `SPIA_NIB_REG |->
      push_word[15:14] == 2'h0 && push_word[13] == cmd.selector_bit &&
      ^push_word)
      else $error("bad register reply format");
   a_next_frame: assert property (@(posedge i_mclk)
      disable iff (i_rst)
      cs_rise |=> !pop [*2])
      else $error("reply taken in same frame");
   // A read seen through a bad readback must not reach the register block.
   a_read_gate: assert property (@(posedge i_mclk)
      disable iff (i_rst)
      eval && !f_full && mis_l |=> !o_reg.rd)
      else $error("read done despite MISO error");
   c_accel_ok: cover property (@(posedge i_mclk)
      push && push_word[15:14] == `SPIA_ACC_HDR);
   c_reg_write: cover property (@(posedge i_mclk) o_reg.wr);
   c_spi_err: cover property (@(posedge i_mclk) o_spi_err);
   c_fifo_full: cover property (@(posedge i_mclk) f_full);
   c_miso_err: cover property (@(posedge i_mclk) o_miso_err);

endmodule
`default_nettype wire

// File: spia_host.sv
// Purpose: Host SPI master model that frames commands for the handler.
// Assumes: SCLK period of 32 mclk cycles, mode 0, MSB first.
// Notes: SCLK rests low between frames; MOSI toggles once released.
`timescale 1ns/1ps
`default_nettype none
module spia_host (
   input wire logic i_mclk,
   input wire logic i_miso,
   input wire logic i_miso_oe_n,
   input wire logic i_corrupt,
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_mosi,
   output logic o_miso_sense
);
   // Readback path: pulled low while released, flipped on request.
   assign o_miso_sense = i_miso_oe_n ? 1'b0 : (i_miso ^ i_corrupt);

   // Idle levels at time zero.
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end

   // Half an SCLK period of 80 ns.
   task automatic half();
      repeat (16) @(posedge i_mclk);
   endtask

   // One framed transfer; the reply is shifted in at each rise.
   task automatic frame(input logic [15:0] cmd, input int edges,
                        output logic [15:0] rsp);
      rsp = 16'h0000;
      o_cs_n <= 1'b0;
      for (int i = 0; i < edges; i++) begin
         o_mosi <= cmd[15 - (i % 16)];
         half();
         o_sclk <= 1'b1;
         rsp = {rsp[14:0], i_miso};
         half();
         o_sclk <= 1'b0;
      end
      half();
      o_cs_n <= 1'b1;
      o_mosi <= ~o_mosi;
      repeat (40) @(posedge i_mclk);
   endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the SPI request handler.
// Assumes: Each reply except the last is checked in the frame after its request.
// Notes: Expected words are built from the reply nibbles and parity.
`timescale 1ns/1ps
`include "spia_params.svh"
`default_nettype none
module testbench;
   logic i_mclk, i_rst, i_reg_bad, corrupt;
   logic [7:0] i_cfg, i_reg_rdata;
   logic [11:0] i_accel;
   spia_pkg::spia_stat_s i_stat;
   wire logic sclk, cs_n, mosi, miso, miso_oe_n, sense;
   wire logic spi_err, miso_err, mismatch;
   spia_pkg::spia_reg_s reg_req;
   logic [15:0] exp_rsp, rsp;
   logic [12:0] wr_seen;
   int n_errors = 0, samples_checked = 0, cyc = 0;
   int n_spi = 0, n_mis = 0, n_mm = 0, n_rd = 0;
   // Configuration against request bits, each one out of step.
   logic [7:0] n_mm_cfg [4] = '{8'h80, 8'h10, 8'h02, 8'h00};
   logic [2:0] n_mm_bits [4] = '{3'b000, 3'b000, 3'b000, 3'b100};

   spia_handler i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(sclk),
      .i_cs_n(cs_n), .i_mosi(mosi), .i_miso_sense(sense),
      .i_device_config_register(i_cfg), .i_stat(i_stat),
      .i_accel(i_accel), .i_reg_rdata(i_reg_rdata),
      .i_reg_bad(i_reg_bad), .o_miso(miso), .o_miso_oe_n(miso_oe_n),
      .o_reg(reg_req), .o_spi_err(spi_err), .o_miso_err(miso_err),
      .o_mismatch(mismatch));
   spia_host i_host (.i_mclk(i_mclk), .i_miso(miso),
      .i_miso_oe_n(miso_oe_n), .i_corrupt(corrupt), .o_sclk(sclk),
      .o_cs_n(cs_n), .o_mosi(mosi), .o_miso_sense(sense));

   // Clock of 5 ns period.
   initial begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end

   // Pulse counters, write capture and the hang limit.
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (spi_err === 1'b1) n_spi <= n_spi + 1;
      if (miso_err === 1'b1) n_mis <= n_mis + 1;
      if (mismatch === 1'b1) n_mm <= n_mm + 1;
      if (reg_req.rd === 1'b1) n_rd <= n_rd + 1;
      if (reg_req.wr === 1'b1) wr_seen <= {reg_req.addr, reg_req.wdata};
      if (cyc == 40000) begin
         n_errors++;
         end_sim();
      end
   end

   // Command word with odd parity over all sixteen bits.
   function automatic logic [15:0] cmd(input logic m, input logic s,
                                       input logic [12:0] r);
      return {~^{m, s, r}, m, s, r};
   endfunction

   // Acceleration request carrying bit 3 and the configuration bits.
   function automatic logic [15:0] acc(input logic s, input logic [2:0] b);
      return cmd(1'b1, s, {10'h001, b});
   endfunction

   // Reply word; bit 12 makes the count of ones odd.
   function automatic logic [15:0] rw(input logic [2:0] t,
                                      input logic [11:0] l);
      logic [15:0] w;
      w = {t, 1'b0, l};
      w[12] = ~^w;
      return w;
   endfunction

   // Fixed error word with a zero data field.
   function automatic logic [15:0] err(input logic [3:0] nib);
      return rw(3'b000, {nib, 8'h00});
   endfunction

   // Comparison that counts and reports.
   task automatic chk(input string what, input logic [15:0] e,
                      input logic [15:0] s);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, e, s);
      end
   endtask

   // One frame: check the reply to the previous request, queue the next.
   task automatic go(input logic [15:0] c, input logic [15:0] nx,
                     input int edges = 16);
      i_host.frame(c, edges, rsp);
      // A short frame only shifts in the leading bits of the reply.
      chk("reply", 16'(exp_rsp >> (16 - edges)), rsp);
      exp_rsp = nx;
   endtask

   // Closing report.
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence.
   initial begin
      i_rst = 1'b1;
      i_reg_bad = 1'b0;
      corrupt = 1'b0;
      i_cfg = 8'h00;
      i_reg_rdata = 8'h5A;
      i_accel = 12'hABC;
      i_stat = '0;
      exp_rsp = `SPIA_RSP_IDLE;
      repeat (8) @(posedge i_mclk);
      i_rst <= 1'b0;
      repeat (8) @(posedge i_mclk);
      go(cmd(1'b0, 1'b0, 13'h0500), rw(3'b000, {4'hE, 8'h5A}));
      go(cmd(1'b0, 1'b1, 13'h033C), rw(3'b001, {4'hE, 8'h3C}));
      i_cfg <= 8'h90;
      go(acc(1'b0, 3'b110), rw(3'b100, 12'hABC));
      chk("write", {3'h0, 13'h033C}, {3'h0, wr_seen});
      $display("test registers finished");
      for (int i = 0; i < 2; i++) begin
         i_cfg <= i ? 8'h04 : 8'h02;
         go(acc(1'b0, 3'b001), rw(3'b100, 12'hABC));
      end
      foreach (n_mm_cfg[k]) begin
         i_cfg <= n_mm_cfg[k];
         go(acc(1'b0, n_mm_bits[k]), err(`SPIA_NIB_IACC));
      end
      go(acc(1'b0, 3'b010), err(`SPIA_NIB_IACC));
      chk("mismatch pulses", 16'h0005, 16'(n_mm));
      i_cfg <= 8'h00;
      go(acc(1'b1, 3'b000), err(`SPIA_NIB_IACC));
      go(acc(1'b0, 3'b000), rw(3'b100, 12'hABC));
      $display("test acceleration finished");
      for (int i = 0; i < 5; i++) begin
         i_stat <= spia_pkg::spia_stat_s'(5'h01 << i);
         go(acc(1'b0, 3'b000), err(`SPIA_NIB_INT));
      end
      i_stat <= '0;
      $display("test status finished");
      go(acc(1'b0, 3'b000) ^ 16'h8000, err(`SPIA_NIB_SPI));
      go(acc(1'b0, 3'b000), err(`SPIA_NIB_SPI), 15);
      chk("spi pulses", 16'h0002, 16'(n_spi));
      corrupt <= 1'b1;
      go(acc(1'b0, 3'b000), err(`SPIA_NIB_MISO));
      corrupt <= 1'b0;
      i_reg_bad <= 1'b1;
      go(cmd(1'b0, 1'b0, 13'h0700), err(`SPIA_NIB_IREG));
      i_reg_bad <= 1'b0;
      go(cmd(1'b0, 1'b0, 13'h0500), `SPIA_RSP_IDLE);
      chk("miso pulses", 16'h0001, 16'(n_mis));
      chk("read pulses", 16'h0002, 16'(n_rd));
      chk("miso enable", 16'h0001, 16'(miso_oe_n));
      $display("test errors finished");
      end_sim();
   end
endmodule
`default_nettype wire
